// *** logic/servo_cmd_pkg.sv ***
// Package for the servo command decoder: register map, field positions,
// reset values and timing constants.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package servo_cmd_pkg;

   // ----------------------------------------------------------------
   // Register indices (printed offsets) and byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CMD = 8'h1e;
   localparam logic [7:0] IDX_ACCEL = 8'h22;
   localparam logic [7:0] IDX_DECEL = 8'h23;
   localparam logic [7:0] IDX_STATUS = 8'h40;
   localparam logic [7:0] IDX_OFFSET = 8'h41;
   localparam logic [7:0] IDX_CONFIG = 8'h42;
   localparam logic [7:0] IDX_PRI_MODE = 8'h43;
   localparam logic [7:0] IDX_SEC_MODE = 8'h44;
   localparam logic [9:0] ADDR_CMD = {IDX_CMD, 2'b00};
   localparam logic [9:0] ADDR_ACCEL = {IDX_ACCEL, 2'b00};
   localparam logic [9:0] ADDR_DECEL = {IDX_DECEL, 2'b00};
   localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [9:0] ADDR_OFFSET = {IDX_OFFSET, 2'b00};
   localparam logic [9:0] ADDR_CONFIG = {IDX_CONFIG, 2'b00};
   localparam logic [9:0] ADDR_PRI_MODE = {IDX_PRI_MODE, 2'b00};
   localparam logic [9:0] ADDR_SEC_MODE = {IDX_SEC_MODE, 2'b00};

   // ----------------------------------------------------------------
   // Command word bit positions
   // ----------------------------------------------------------------
   localparam int B_SERVO_ON = 0;
   localparam int B_PROFILE = 1;
   localparam int B_DEV_CLR = 2;
   localparam int B_ALM_CLR = 3;
   localparam int B_HARD_STOP = 4;
   localparam int B_SMOOTH_STOP = 5;
   localparam int B_RAMP_EN = 7;
   localparam int B_ZERO_CAL = 8;
   localparam int B_MODE2 = 9;
   localparam int B_LIMIT2 = 10;
   // Bits that store; bit 6 and bits 11..15 read as zero
   localparam logic [15:0] CMD_MASK = 16'h07bf;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_CMD = 16'h0000;
   localparam logic [15:0] RST_ACCEL = 16'h03e8;
   localparam logic [15:0] RST_DECEL = 16'h03e8;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [7:0] RST_IO_FUNC = 8'h00;
   localparam logic [7:0] IO_FUNC_MODE_SW = 8'h10;
   localparam logic [7:0] RST_PRI_MODE = 8'h00;
   localparam logic [7:0] RST_SEC_MODE = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 10000000;
   localparam longint CAL_TIME_MS = 100;
   localparam longint CAL_CYCLES = CLK_HZ * CAL_TIME_MS / 1000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** logic/servo_command_decoder.sv ***
// Servo command decoder: holds the servo command word and ramp rates,
// decodes the word into control levels for the motor loops.
// Assumes one 10 MHz clock, an AXI4-Lite master, and a motor core that
// acts on the decoded levels and returns alarm and motion status.
// Function
// - Bit 0 energizes servo, holds shaft.
// - I/O servo-enable input also enables servo.
// - Bit 1 runs profile position control.
// - Bit 2 clears position error.
// - Deviation clear only in pulse mode; holds.
// - Deviation clear bit persists until written zero.
// - Bit 3 write-one clears active alarm.
// - Bit 4 forces zero speed immediately.
// - Hard stop blocks motion in all modes.
// - Bit 5 ramps down at decel rate.
// - Smooth stop blocks motion in all modes.
// - Bit 7 enables ramps in speed mode.
// - Ramps always on homing and smooth stop.
// - Bit 8 averages analog input 0.1 s.
// - Bit 9 selects first or second mode.
// - Mode switch keeps servo enable.
// - Bit 10 selects current limit pair.
// - I/O configured 0x10 switches control mode.
`timescale 1ns/100ps
`default_nettype none

module servo_command_decoder
   import servo_cmd_pkg::*;
#(
   parameter longint CAL_CYC = CAL_CYCLES,
   parameter int CAL_SHIFT = 20
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Connector pins
   input wire logic servo_on_pin,
   input wire logic mode_sw_pin,
   // Motor core feedback (same clock)
   input wire logic pulse_input_mode,
   input wire logic speed_mode,
   input wire logic homing_mode,
   input wire logic alarm_active,
   input wire logic [15:0] analog_sample,
   input wire logic analog_sample_valid,
   // Decoded controls
   output logic servo_enable,
   output logic profile_run,
   output logic deviation_clear,
   output logic hold_position,
   output logic alarm_clear,
   output logic zero_speed,
   output logic smooth_stop,
   output logic motion_inhibit,
   output logic ramp_enable,
   output logic [15:0] accel_out,
   output logic [15:0] decel_out,
   output logic [15:0] analog_offset_param,
   output logic cal_busy,
   output logic mode_second,
   output logic [7:0] active_mode_param,
   output logic limit_second
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [15:0] cmd_r;
   logic [15:0] accel_r;
   logic [15:0] decel_r;
   logic [15:0] offset_r;
   logic [7:0] io_func_r;
   logic [7:0] pri_mode_r;
   logic [7:0] sec_mode_r;
   logic servo_meta_r, servo_sync_r;
   logic mode_meta_r, mode_sync_r;
   logic alarm_clr_r;
   logic aw_hold_r, w_hold_r;
   logic [9:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [15:0] dec_word;
   logic do_write;
   logic [31:0] cal_cnt_r;
   logic [39:0] cal_sum_r;
   logic [39:0] cal_sum_nxt;
   logic cal_run_r;
   logic cal_req;

   // Merge one 16-bit register with byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Address decoder: one when the byte address is mapped
   function automatic logic mapped(input logic [9:0] a);
      mapped = (a == ADDR_CMD) || (a == ADDR_ACCEL) || (a == ADDR_DECEL) ||
               (a == ADDR_STATUS) || (a == ADDR_OFFSET) ||
               (a == ADDR_CONFIG) || (a == ADDR_PRI_MODE) ||
               (a == ADDR_SEC_MODE);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         servo_meta_r <= 1'b0;
         servo_sync_r <= 1'b0;
         mode_meta_r <= 1'b0;
         mode_sync_r <= 1'b0;
      end else begin
         servo_meta_r <= servo_on_pin;
         servo_sync_r <= servo_meta_r;
         mode_meta_r <= mode_sw_pin;
         mode_sync_r <= mode_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Write channel: address and data captured in either order
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign do_write = aw_hold_r && w_hold_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 10'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[9:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Command word and parameter registers
   // ----------------------------------------------------------------
   assign dec_word = merge16(cmd_r, wdata_r, wstrb_r) & CMD_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_r <= RST_CMD;
         accel_r <= RST_ACCEL;
         decel_r <= RST_DECEL;
         io_func_r <= RST_IO_FUNC;
         pri_mode_r <= RST_PRI_MODE;
         sec_mode_r <= RST_SEC_MODE;
      end else if (do_write) begin
         case (awaddr_r)
            // Every stored bit is a plain level kept until rewritten
            ADDR_CMD: cmd_r <= dec_word;
            ADDR_ACCEL: accel_r <= merge16(accel_r, wdata_r, wstrb_r);
            ADDR_DECEL: decel_r <= merge16(decel_r, wdata_r, wstrb_r);
            ADDR_CONFIG: begin
               if (wstrb_r[0]) io_func_r <= wdata_r[7:0];
            end
            ADDR_PRI_MODE: begin
               if (wstrb_r[0]) pri_mode_r <= wdata_r[7:0];
            end
            ADDR_SEC_MODE: begin
               if (wstrb_r[0]) sec_mode_r <= wdata_r[7:0];
            end
            default: ;
         endcase
      end
   end

   // Alarm clear pulse on each write of one to the alarm clear bit while alarm_active is high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_clr_r <= 1'b0;
      end else begin
         alarm_clr_r <= do_write && (awaddr_r == ADDR_CMD) &&
                        dec_word[B_ALM_CLR] && alarm_active;
      end
   end


   // ----------------------------------------------------------------
   // Read channel: one outstanding read, data from flip-flops
   // ----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped({s_axi_araddr[9:2], 2'b00}) ?
                        RESP_OKAY : RESP_SLVERR;
         case ({s_axi_araddr[9:2], 2'b00})
            ADDR_CMD: s_axi_rdata <= {16'h0000, cmd_r};
            ADDR_ACCEL: s_axi_rdata <= {16'h0000, accel_r};
            ADDR_DECEL: s_axi_rdata <= {16'h0000, decel_r};
            ADDR_STATUS: s_axi_rdata <= {24'h000000, 1'b0, cal_run_r,
                                         alarm_active, mode_second,
                                         limit_second, motion_inhibit,
                                         servo_enable, profile_run};
            ADDR_OFFSET: s_axi_rdata <= {16'h0000, offset_r};
            ADDR_CONFIG: s_axi_rdata <= {24'h000000, io_func_r};
            ADDR_PRI_MODE: s_axi_rdata <= {24'h000000, pri_mode_r};
            ADDR_SEC_MODE: s_axi_rdata <= {24'h000000, sec_mode_r};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Analog zero-offset calibration
   // ----------------------------------------------------------------
   // Starts on a write that raises bit 8; input must be at zero level
   assign cal_req = do_write && (awaddr_r == ADDR_CMD) &&
                    dec_word[B_ZERO_CAL] && !cmd_r[B_ZERO_CAL];

   // Running sum with the current sample; 40 bits hold 2**20 full samples
   assign cal_sum_nxt = cal_sum_r + (analog_sample_valid ?
                        {{24{analog_sample[15]}}, analog_sample} : 40'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_run_r <= 1'b0;
         cal_cnt_r <= 32'h00000000;
         cal_sum_r <= '0;
         offset_r <= RST_OFFSET;
      end else if (cal_req && !cal_run_r) begin
         cal_run_r <= 1'b1;
         cal_cnt_r <= 32'h00000000;
         cal_sum_r <= '0;
      end else if (cal_run_r) begin
         // Averaging sum of signed samples over the window
         cal_sum_r <= cal_sum_nxt;
         if (cal_cnt_r == 32'(CAL_CYC - 1)) begin
            cal_run_r <= 1'b0;
            // Mean includes the last sample; signed shift keeps the sign
            // Caller sizes CAL_SHIFT to the sample count
            offset_r <= 16'($signed(cal_sum_nxt) >>> CAL_SHIFT);
         end else begin
            cal_cnt_r <= cal_cnt_r + 32'h00000001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Decoded control outputs
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         servo_enable <= 1'b0;
         profile_run <= 1'b0;
         deviation_clear <= 1'b0;
         hold_position <= 1'b0;
         alarm_clear <= 1'b0;
         zero_speed <= 1'b0;
         smooth_stop <= 1'b0;
         motion_inhibit <= 1'b0;
         ramp_enable <= 1'b0;
         mode_second <= 1'b0;
         limit_second <= 1'b0;
         active_mode_param <= RST_PRI_MODE;
      end else begin
         // Servo on from word or pin; unaffected by mode select
         servo_enable <= cmd_r[B_SERVO_ON] || servo_sync_r;
         profile_run <= cmd_r[B_PROFILE] && !cmd_r[B_HARD_STOP] &&
                        !cmd_r[B_SMOOTH_STOP];
         deviation_clear <= cmd_r[B_DEV_CLR] && pulse_input_mode;
         hold_position <= cmd_r[B_DEV_CLR] && pulse_input_mode;
         alarm_clear <= alarm_clr_r;
         zero_speed <= cmd_r[B_HARD_STOP];
         smooth_stop <= cmd_r[B_SMOOTH_STOP];
         motion_inhibit <= cmd_r[B_HARD_STOP] ||
                           cmd_r[B_SMOOTH_STOP];
         ramp_enable <= (cmd_r[B_RAMP_EN] && speed_mode) ||
                        homing_mode || cmd_r[B_SMOOTH_STOP];
         mode_second <= (io_func_r == IO_FUNC_MODE_SW) ?
                        mode_sync_r : cmd_r[B_MODE2];
         active_mode_param <= ((io_func_r == IO_FUNC_MODE_SW) ?
                               mode_sync_r : cmd_r[B_MODE2]) ?
                              sec_mode_r : pri_mode_r;
         limit_second <= cmd_r[B_LIMIT2];
      end
   end

   // Ramp rates; smooth stop decelerates at decel_out
   assign accel_out = accel_r;
   assign decel_out = decel_r;
   assign analog_offset_param = offset_r;
   assign cal_busy = cal_run_r;

endmodule // servo_command_decoder

`default_nettype wire

// *** verif/servo_cmd_sva.sv ***
// Checker for the servo command decoder: bus handshake and decode relations.
// Assumes it is bound to servo_command_decoder and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module servo_cmd_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Motor core mode
   input wire logic pulse_input_mode,
   // Decoded controls
   input wire logic profile_run,
   input wire logic deviation_clear,
   input wire logic hold_position,
   input wire logic alarm_clear,
   input wire logic zero_speed,
   input wire logic smooth_stop,
   input wire logic motion_inhibit,
   input wire logic ramp_enable,
   input wire logic [15:0] accel_out
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_wblock;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wblock: assert property (p_wblock) else $error("write taken too early");
   property p_wresp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wresp: assert property (p_wresp) else $error("write response late");
   property p_rresp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rresp: assert property (p_rresp) else $error("read response late");
   property p_hard;
      zero_speed |-> motion_inhibit && !profile_run;
   endproperty
   a_hard: assert property (p_hard) else $error("hard stop lets motion");
   property p_smooth;
      smooth_stop |-> motion_inhibit && ramp_enable && !profile_run;
   endproperty
   a_smooth: assert property (p_smooth) else $error("smooth stop bad");
   property p_hold;
      hold_position |-> deviation_clear && $past(pulse_input_mode);
   endproperty
   a_hold: assert property (p_hold) else $error("hold without clear");
   property p_pulse;
      alarm_clear |=> !alarm_clear;
   endproperty
   a_pulse: assert property (p_pulse) else $error("alarm clear too long");
   property p_rst;
      disable iff (1'b0) !aresetn |=> accel_out == 16'h03e8;
   endproperty
   a_rst: assert property (p_rst) else $error("accel reset value");
   // Main scenarios reached
   c_alarm: cover property (alarm_clear);
   c_hold: cover property (hold_position);
   c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // servo_cmd_sva
bind servo_command_decoder servo_cmd_sva i_sva (.*);
`default_nettype wire

// *** verif/servo_host_model.sv ***
// Host controller model: AXI4-Lite master issuing single register cycles.
// Assumes one clock shared with the decoder; called from the bench.
`timescale 1ns/100ps
`default_nettype none
module servo_host_model (
   // Clock
   input wire logic aclk,
   // Master side of the register bus
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [31:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
   end
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [31:0] a, input logic [15:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a; // Released address no longer valid
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~{16'h0000, d};
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
endmodule // servo_host_model
`default_nettype wire

// *** verif/servo_command_decoder_tb_top.sv ***
// Self-checking bench for the servo command decoder.
// Assumes the host model for bus cycles and a shortened calibration window.
`timescale 1ns/100ps
`default_nettype none
module servo_command_decoder_tb_top;
   import servo_cmd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, cal_busy, mode_second, limit_second;
   logic servo_on_pin = 0, mode_sw_pin = 0, pulse_input_mode = 0;
   logic speed_mode = 0, homing_mode = 0, alarm_active = 0;
   logic [15:0] analog_sample = 16'h0000;
   logic analog_sample_valid = 1'b0;
   logic servo_enable, profile_run, deviation_clear, hold_position;
   logic alarm_clear, zero_speed, smooth_stop, motion_inhibit, ramp_enable;
   logic [15:0] accel_out, decel_out, analog_offset_param;
   logic [7:0] active_mode_param;
   int fail_count = 0, check_count = 0, pulses = 0, cycles = 0;
   servo_command_decoder #(.CAL_CYC(16), .CAL_SHIFT(4)) i_dut (.*);
   servo_host_model i_host (.*);
   initial forever #50 aclk = ~aclk;
   // Cycle limit and alarm clear pulse counter
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (alarm_clear === 1'b1) pulses = pulses + 1;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] v);
      i_host.wr({22'h0, a}, v, rsp);
      chk(32'(rsp), 32'(RESP_OKAY));
   endtask
   task automatic rd(input logic [9:0] a);
      i_host.rd({22'h0, a}, d, rsp);
      chk(32'(rsp), 32'(RESP_OKAY));
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rd(ADDR_CMD);
      chk(d, 32'h0);
      rd(ADDR_ACCEL);
      chk(d, 32'h3e8);
      rd(ADDR_DECEL);
      chk(d, 32'h3e8);
      i_host.rd(32'h0000_03fc, d, rsp);
      chk(32'(rsp), 32'(RESP_SLVERR));
      chk(d, 32'h0);
      i_host.wr(32'h0000_03fc, 16'h1234, rsp);
      chk(32'(rsp), 32'(RESP_SLVERR));
      wr(ADDR_CMD, 16'hffff);
      rd(ADDR_CMD);
      chk(d, 32'h07bf);
      wr(ADDR_CMD, 16'h0000);
      $display("regs done");
   endtask
   task automatic t_decode();
      int bits[8] = '{0, 1, 2, 4, 5, 7, 9, 10};
      logic [8:0] ex[8] = '{9'h001, 9'h002, 9'h004, 9'h108, 9'h130,
                            9'h020, 9'h040, 9'h080};
      pulse_input_mode <= 1'b1;
      speed_mode <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CMD, 16'h0001 << bits[i]);
         wt(2);
         chk(32'({motion_inhibit, limit_second, mode_second, ramp_enable,
                  smooth_stop, zero_speed, deviation_clear, profile_run,
                  servo_enable}), 32'(ex[i]));
      end
      $display("decode done");
   endtask
   task automatic t_stop();
      wr(ADDR_CMD, 16'h0013);
      wt(2);
      chk(32'({profile_run, zero_speed, motion_inhibit}), 32'h3);
      wr(ADDR_DECEL, 16'h0123);
      wr(ADDR_CMD, 16'h0023);
      wt(2);
      chk(32'(profile_run), 32'h0);
      chk(32'(decel_out), 32'h0123);
      speed_mode <= 1'b0;
      wr(ADDR_CMD, 16'h0080);
      wt(2);
      chk(32'(ramp_enable), 32'h0);
      homing_mode <= 1'b1;
      wt(3);
      chk(32'(ramp_enable), 32'h1);
      homing_mode <= 1'b0;
      $display("stop done");
   endtask
   task automatic t_dev();
      pulse_input_mode <= 1'b0;
      wr(ADDR_CMD, 16'h0004);
      wt(3);
      chk(32'(hold_position), 32'h0);
      pulse_input_mode <= 1'b1;
      wt(3);
      chk(32'(hold_position), 32'h1);
      wt(20);
      rd(ADDR_CMD);
      chk(d, 32'h4);
      wr(ADDR_CMD, 16'h0000);
      wt(2);
      chk(32'(deviation_clear), 32'h0);
      $display("deviation done");
   endtask
   task automatic t_alarm();
      alarm_active <= 1'b1;
      pulses = 0;
      wr(ADDR_CMD, 16'h0008);
      wt(4);
      chk(32'(pulses), 32'h1);
      alarm_active <= 1'b0; // Cause removed before the next clear
      wr(ADDR_CMD, 16'h0000);
      pulses = 0;
      wr(ADDR_CMD, 16'h0008);
      wt(4);
      chk(32'(pulses), 32'h0);
      wr(ADDR_CMD, 16'h0000);
      $display("alarm done");
   endtask
   task automatic t_mode();
      wr(ADDR_PRI_MODE, 16'h0011);
      wr(ADDR_SEC_MODE, 16'h0022);
      wr(ADDR_CMD, 16'h0001);
      wr(ADDR_CMD, 16'h0201);
      wt(2);
      chk(32'(servo_enable), 32'h1);
      chk(32'(active_mode_param), 32'h22);
      wr(ADDR_CMD, 16'h0001);
      wr(ADDR_CONFIG, {8'h00, IO_FUNC_MODE_SW});
      mode_sw_pin <= 1'b1;
      wt(5);
      chk(32'(mode_second), 32'h1);
      mode_sw_pin <= 1'b0;
      wt(5);
      chk(32'(active_mode_param), 32'h11);
      wr(ADDR_CMD, 16'h0000);
      servo_on_pin <= 1'b1;
      wt(5);
      chk(32'(servo_enable), 32'h1);
      servo_on_pin <= 1'b0;
      wt(5);
      chk(32'(servo_enable), 32'h0);
      $display("mode done");
   endtask
   task automatic t_cal();
      int n;
      n = 0;
      analog_sample <= 16'h0005; // Near-zero level held during the window
      analog_sample_valid <= 1'b1;
      wr(ADDR_CMD, 16'h0100);
      rd(ADDR_STATUS);
      chk(d, 32'h40);
      wt(2);
      chk(32'(cal_busy), 32'h1);
      while (cal_busy === 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(analog_offset_param), 32'h5);
      rd(ADDR_OFFSET);
      chk(d, 32'h5);
      analog_sample_valid <= 1'b0;
      wr(ADDR_CMD, 16'h0000);
      $display("calibration done");
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_decode();
      t_stop();
      t_dev();
      t_alarm();
      t_mode();
      t_cal();
      final_report();
   end
endmodule // servo_command_decoder_tb_top
`default_nettype wire
